// ---- hdl/apc_map.svh ----
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define APC_OFF_SETPOINT     3'h0
`define APC_OFF_AUX_REF      3'h1
`define APC_OFF_PERIPH_EN    3'h2
`define APC_OFF_DEADTIME     3'h3
`define APC_OFF_MODE         3'h4
`define APC_OFF_BLOCK_EN     3'h5
`define APC_OFF_STEER_TIMING 3'h6
`define APC_OFF_STATUS       3'h7

// ----------------------------------------
// Peripheral enable fields
// ----------------------------------------
`define APC_PE_PRIMARY_GATE_DRIVE_EN   7
`define APC_PE_SECONDARY_GATE_DRIVE_EN   6
`define APC_PE_PRIMARY_GATE_DRIVE_BY   5
`define APC_PE_SECONDARY_GATE_DRIVE_BY   4
`define APC_PE_UNIMPL    3
`define APC_PE_PULLUP    2
`define APC_PE_STEER_P   1
`define APC_PE_STEER_S   0
`define APC_PE_WMASK     8'hF7

// ----------------------------------------
// Other fields
// ----------------------------------------
`define APC_DT_P_HI      7
`define APC_DT_P_LO      4
`define APC_DT_S_HI      3
`define APC_DT_S_LO      0
`define APC_MS_HI        7
`define APC_MS_LO        6
`define APC_BE_DIG_EN    7
`define APC_BE_DSEL_HI   6
`define APC_BE_DSEL_LO   4
`define APC_BE_ANA_EN    0
`define APC_BE_WMASK     8'hF1
`define APC_ST_DUTY_HI   7
`define APC_ST_DUTY_LO   0
`define APC_ST_PER_HI    15
`define APC_ST_PER_LO    8
`define APC_RESET_BYTE   8'h00
`define APC_DSEL_UNUSED  3'h7
`define APC_MS_MASTER    2'h1
`define APC_MS_SLAVE     2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define APC_CLK_PERIOD_NS 10
`define APC_DT_STEP_NS    16

`endif

// ---- hdl/apc_pkg.sv ----
package apc_pkg;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } apc_bus_req_t;

    typedef enum logic [1:0] {
        APC_MS_STANDALONE,
        APC_MS_MASTER,
        APC_MS_SLAVE,
        APC_MS_SEMI_MASTER
    } apc_ms_mode_t;

endpackage

// ---- hdl/apc_regs.sv ----
`timescale 1ns/1ps
`include "apc_map.svh"

// What this block does
// - Setpoint register drives current reference DAC code.
// - DAC codes span 0..255 linear steps.
// - Lower of two amplifier demands governs loop.
// - Aux reference reaches pin only in master.
// - Bits 7/6 enable primary/secondary gate drive.
// - Bits 5/4 bypass primary/secondary dead time.
// - Dead time 16 to 256 ns, 16 ns steps.
// - Bit 2 enables sense pin weak pull-up.
// - Bit 1 steers open-loop PWM to primary.
// - Bit 0 steers open-loop PWM to secondary.
// - Secondary steering pulses only with overvoltage active.
// - Steering period and duty from timer registers.
// - Primary steering dominates when both set.
// - Digital test enable routes selected channel out.
// - Analog test enable buffers analog mux out.
// - Digital test wins when both enables set.
// - Analog test goes to ADC when disabled.
// - Bit 3 unimplemented, reads zero.
// - Select codes 0..6 valid, 7 unimplemented.
// - Mode field decodes four master/slave modes.
module apc_regs #(
    parameter int DATA_W    = 8,
    parameter int STEER_DIV = 1
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // Register port
    input  wire apc_pkg::apc_bus_req_t bus_req,
    output logic [7:0]                 rd_data,
    // Analog and timing inputs
    input  wire logic [7:0]            current_demand,
    input  wire logic [7:0]            voltage_demand,
    input  wire logic                  loop_pwm_primary,
    input  wire logic                  loop_pwm_secondary,
    input  wire logic                  overvoltage_active,
    input  wire logic [6:0]            dig_test_in,
    // Reference outputs
    output logic [7:0]                 current_dac_code,
    output logic [7:0]                 aux_dac_code,
    output logic                       aux_ref_to_pin,
    output logic [7:0]                 loop_demand,
    // Gate drives and pull-up
    output logic                       primary_gate_drive,
    output logic                       secondary_gate_drive,
    output logic                       sense_pin_pullup_enable,
    // Mode
    output apc_pkg::apc_ms_mode_t      ms_mode,
    output logic                       ext_sync_select,
    // Debug pin routing
    output logic                       debug_pin_out,
    output logic                       debug_pin_oe,
    output logic                       analog_buffer_to_pin,
    output logic                       analog_to_adc
);

    if (DATA_W != 8 || STEER_DIV < 1 || STEER_DIV > 65535) begin : g_bad_params
        $error("apc_regs: unsupported parameter values");
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0]  setpoint;
    logic [7:0]  aux_ref;
    logic [7:0]  periph_en;
    logic [7:0]  deadtime_code;
    logic [7:0]  mode_reg;
    logic [7:0]  block_en;
    logic [15:0] steer_timing;
    logic [1:0]  drive_q;
    logic        steer_pwm;

    wire wr_set  = bus_req.wr && bus_req.addr == `APC_OFF_SETPOINT;
    wire wr_aux  = bus_req.wr && bus_req.addr == `APC_OFF_AUX_REF;
    wire wr_pe   = bus_req.wr && bus_req.addr == `APC_OFF_PERIPH_EN;
    wire wr_dt   = bus_req.wr && bus_req.addr == `APC_OFF_DEADTIME;
    wire wr_mode = bus_req.wr && bus_req.addr == `APC_OFF_MODE;
    wire wr_be   = bus_req.wr && bus_req.addr == `APC_OFF_BLOCK_EN;
    wire wr_st   = bus_req.wr && bus_req.addr == `APC_OFF_STEER_TIMING;
    wire wr_per  = bus_req.wr && bus_req.addr == `APC_OFF_STATUS;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            setpoint      <= `APC_RESET_BYTE;
            aux_ref       <= `APC_RESET_BYTE;
            periph_en     <= `APC_RESET_BYTE;
            deadtime_code <= `APC_RESET_BYTE;
            mode_reg      <= `APC_RESET_BYTE;
            block_en      <= `APC_RESET_BYTE;
            steer_timing  <= {`APC_RESET_BYTE, `APC_RESET_BYTE};
        end else begin
            if (wr_set) setpoint <= bus_req.wdata;
            if (wr_aux) aux_ref <= bus_req.wdata;
            if (wr_pe) periph_en <= bus_req.wdata & `APC_PE_WMASK;
            if (wr_dt) deadtime_code <= bus_req.wdata;
            if (wr_mode) mode_reg <= bus_req.wdata;
            if (wr_be) block_en <= bus_req.wdata & `APC_BE_WMASK;
            if (wr_st) steer_timing[`APC_ST_DUTY_HI:`APC_ST_DUTY_LO] <= bus_req.wdata;
            // Status index is read-only, so its write slot takes the period
            if (wr_per) steer_timing[`APC_ST_PER_HI:`APC_ST_PER_LO] <= bus_req.wdata;
        end
    end

    // Duty reads back at its index; the period byte is write-only
    wire [7:0] steer_duty = steer_timing[`APC_ST_DUTY_HI:`APC_ST_DUTY_LO];

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire [7:0] status_byte = {4'h0, steer_pwm, overvoltage_active, drive_q[1], drive_q[0]};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus_req.addr)
            `APC_OFF_SETPOINT:     rd_mux = setpoint;
            `APC_OFF_AUX_REF:      rd_mux = aux_ref;
            `APC_OFF_PERIPH_EN:    rd_mux = periph_en;
            `APC_OFF_DEADTIME:     rd_mux = deadtime_code;
            `APC_OFF_MODE:         rd_mux = mode_reg;
            `APC_OFF_BLOCK_EN:     rd_mux = block_en;
            `APC_OFF_STEER_TIMING: rd_mux = steer_duty;
            `APC_OFF_STATUS:       rd_mux = status_byte;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rd_data <= `APC_RESET_BYTE;
        end else begin
            rd_data <= bus_req.rd ? rd_mux : `APC_RESET_BYTE;
        end
    end

    // ----------------------------------------
    // References, mode and demand selection
    // ----------------------------------------
    wire [1:0] ms_field = mode_reg[`APC_MS_HI:`APC_MS_LO];
    wire [7:0] min_demand = (current_demand < voltage_demand) ? current_demand
                                                              : voltage_demand;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            current_dac_code <= `APC_RESET_BYTE;
            aux_dac_code     <= `APC_RESET_BYTE;
            aux_ref_to_pin   <= 1'b0;
            loop_demand      <= `APC_RESET_BYTE;
            ms_mode          <= apc_pkg::APC_MS_STANDALONE;
            ext_sync_select  <= 1'b0;
        end else begin
            current_dac_code <= setpoint;
            aux_dac_code     <= aux_ref;
            aux_ref_to_pin   <= ms_field == `APC_MS_MASTER;
            loop_demand      <= min_demand;
            ms_mode          <= apc_pkg::apc_ms_mode_t'(ms_field);
            ext_sync_select  <= ms_field == `APC_MS_SLAVE;
        end
    end

    // ----------------------------------------
    // Open-loop steering PWM
    // ----------------------------------------
    logic [15:0] div_cnt;
    logic [7:0]  period_cnt;
    wire         div_tick = div_cnt == 16'(STEER_DIV - 1);
    wire [7:0]   steer_period = steer_timing[`APC_ST_PER_HI:`APC_ST_PER_LO];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_cnt    <= 16'h0000;
            period_cnt <= 8'h00;
            steer_pwm  <= 1'b0;
        end else begin
            div_cnt <= div_tick ? 16'h0000 : div_cnt + 16'h0001;
            if (div_tick) begin
                // Period from one register, duty from the other
                period_cnt <= (period_cnt >= steer_period) ? 8'h00
                                                           : period_cnt + 8'h01;
                steer_pwm  <= period_cnt < steer_duty;
            end
        end
    end

    // ----------------------------------------
    // Drive request steering
    // ----------------------------------------
    wire steer_p = periph_en[`APC_PE_STEER_P];
    wire steer_s = periph_en[`APC_PE_STEER_S] && !steer_p;
    wire [1:0] drive_req;
    assign drive_req[0] = steer_p ? steer_pwm : (!steer_s && loop_pwm_primary);
    assign drive_req[1] = steer_s ? (steer_pwm && overvoltage_active)
                                  : (!steer_p && loop_pwm_secondary);

    wire [1:0] drive_en = {periph_en[`APC_PE_SECONDARY_GATE_DRIVE_EN], periph_en[`APC_PE_PRIMARY_GATE_DRIVE_EN]};
    wire [1:0] drive_by = {periph_en[`APC_PE_SECONDARY_GATE_DRIVE_BY], periph_en[`APC_PE_PRIMARY_GATE_DRIVE_BY]};
    wire [3:0] dt_code [2];
    assign dt_code[0] = deadtime_code[`APC_DT_P_HI:`APC_DT_P_LO];
    assign dt_code[1] = deadtime_code[`APC_DT_S_HI:`APC_DT_S_LO];

    // ----------------------------------------
    // Dead time per drive
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_drive
            logic [4:0] dt_cnt;
            wire [8:0] dt_ns  = 9'(({5'h00, dt_code[gi]} + 9'h001)
                                   * 9'(`APC_DT_STEP_NS));
            // Least time, so round up to whole cycles
            wire [4:0] dt_cyc = 5'((dt_ns + 9'(`APC_CLK_PERIOD_NS - 1))
                                   / 9'(`APC_CLK_PERIOD_NS));
            wire       dt_done = dt_cnt >= dt_cyc;

            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    dt_cnt      <= 5'h00;
                    drive_q[gi] <= 1'b0;
                end else begin
                    if (!drive_req[gi]) dt_cnt <= 5'h00;
                    else if (!dt_done) dt_cnt <= dt_cnt + 5'h01;
                    // Turn-off is immediate; only turn-on is delayed
                    drive_q[gi] <= drive_en[gi] && drive_req[gi]
                                   && (drive_by[gi] || dt_done);
                end
            end
        end
    endgenerate

    assign primary_gate_drive   = drive_q[0];
    assign secondary_gate_drive = drive_q[1];

    // ----------------------------------------
    // Pull-up and debug pin routing
    // ----------------------------------------
    wire [2:0] dsel    = block_en[`APC_BE_DSEL_HI:`APC_BE_DSEL_LO];
    wire       dig_en  = block_en[`APC_BE_DIG_EN];
    wire       ana_en  = block_en[`APC_BE_ANA_EN];
    wire       dig_bit = (dsel == `APC_DSEL_UNUSED) ? 1'b0 : dig_test_in[dsel];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sense_pin_pullup_enable <= 1'b0;
            debug_pin_out           <= 1'b0;
            debug_pin_oe            <= 1'b0;
            analog_buffer_to_pin    <= 1'b0;
            analog_to_adc           <= 1'b1;
        end else begin
            sense_pin_pullup_enable <= periph_en[`APC_PE_PULLUP];
            debug_pin_out           <= dig_en && dig_bit;
            debug_pin_oe            <= dig_en;
            analog_buffer_to_pin    <= ana_en && !dig_en;
            analog_to_adc           <= !ana_en;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_pe_bit3_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        bus_req.rd && bus_req.addr == `APC_OFF_PERIPH_EN |=> rd_data[`APC_PE_UNIMPL] == 1'b0)
        else $error("unimplemented enable bit read back as one");

    a_write_lands: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_set |=> ##1 current_dac_code == $past(bus_req.wdata, 2))
        else $error("setpoint write did not reach dac code");

    a_read_once: assert property (@(posedge core_clk) disable iff (!rst_b)
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("read data present without read strobe");

    a_min_demand: assert property (@(posedge core_clk) disable iff (!rst_b)
        1'b1 |=> loop_demand <= $past(current_demand) && loop_demand <= $past(voltage_demand))
        else $error("loop demand not the lower demand");

    a_aux_pin_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        aux_ref_to_pin |-> $past(ms_field) == `APC_MS_MASTER)
        else $error("aux reference on pin outside master mode");

    a_drive_disabled: assert property (@(posedge core_clk) disable iff (!rst_b)
        !periph_en[`APC_PE_PRIMARY_GATE_DRIVE_EN] |=> !primary_gate_drive)
        else $error("primary drive active while disabled");

    a_steer_priority: assert property (@(posedge core_clk) disable iff (!rst_b)
        periph_en[`APC_PE_STEER_P] |=> !secondary_gate_drive)
        else $error("secondary drive pulsed under primary steering");

    a_ov_gates_steer: assert property (@(posedge core_clk) disable iff (!rst_b)
        steer_s && !overvoltage_active |=> !secondary_gate_drive)
        else $error("secondary steering pulsed without overvoltage");

    a_deadtime_min: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($rose(drive_req[0]) && drive_en[0] && !drive_by[0] && dt_code[0] == 4'h0)
        ##1 (drive_req[0] && drive_en[0] && !drive_by[0] && dt_code[0] == 4'h0)[*3]
        |-> primary_gate_drive && !$past(primary_gate_drive))
        else $error("primary turn-on not delayed two cycles");

    a_debug_priority: assert property (@(posedge core_clk) disable iff (!rst_b)
        dig_en |=> debug_pin_oe && !analog_buffer_to_pin)
        else $error("analog buffer on pin while digital test enabled");

    a_aux_lands: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_aux |=> ##1 aux_dac_code == $past(bus_req.wdata, 2))
        else $error("aux write did not reach dac code");

    a_read_match: assert property (@(posedge core_clk) disable iff (!rst_b)
        bus_req.rd && bus_req.addr == `APC_OFF_SETPOINT |=> rd_data == current_dac_code)
        else $error("setpoint read differs from dac code");

    a_pullup_lands: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_pe |=> ##1 sense_pin_pullup_enable == $past(bus_req.wdata[`APC_PE_PULLUP], 2))
        else $error("pull-up enable did not follow its bit");

    a_secondary_gate_drive_disabled: assert property (@(posedge core_clk) disable iff (!rst_b)
        !drive_en[1] |=> !secondary_gate_drive)
        else $error("secondary drive active while disabled");

    a_bypass_primary: assert property (@(posedge core_clk) disable iff (!rst_b)
        drive_en[0] && drive_by[0] && drive_req[0] |=> primary_gate_drive)
        else $error("bypassed primary drive did not follow request");

    a_bypass_secondary: assert property (@(posedge core_clk) disable iff (!rst_b)
        drive_en[1] && drive_by[1] && drive_req[1] |=> secondary_gate_drive)
        else $error("bypassed secondary drive did not follow request");

    a_dt_first_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
        drive_en[1] && !drive_by[1] && $rose(drive_req[1]) |=> !secondary_gate_drive)
        else $error("secondary turn-on skipped its dead time");

    a_steer_primary: assert property (@(posedge core_clk) disable iff (!rst_b)
        steer_p && drive_en[0] && drive_by[0] |=> primary_gate_drive == $past(steer_pwm))
        else $error("primary drive did not follow steering pwm");

    a_steer_secondary: assert property (@(posedge core_clk) disable iff (!rst_b)
        steer_s && drive_en[1] && drive_by[1]
        |=> secondary_gate_drive == $past(steer_pwm && overvoltage_active))
        else $error("secondary drive did not follow gated steering pwm");

    a_steer_s_only: assert property (@(posedge core_clk) disable iff (!rst_b)
        steer_s |=> !primary_gate_drive)
        else $error("primary drive active under secondary steering");

    a_duty_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        div_tick && steer_duty == 8'h00 |=> !steer_pwm)
        else $error("steering pwm high with zero duty");

    a_period_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
        div_tick && period_cnt >= steer_period |=> period_cnt == 8'h00)
        else $error("steering period counter did not wrap");

    a_analog_to_adc: assert property (@(posedge core_clk) disable iff (!rst_b)
        !ana_en |=> analog_to_adc && !analog_buffer_to_pin)
        else $error("analog test signals not routed to converter");

    a_analog_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
        ana_en && !dig_en |=> analog_buffer_to_pin && !debug_pin_oe)
        else $error("analog test signals not buffered to pin");

    a_dig_route: assert property (@(posedge core_clk) disable iff (!rst_b)
        dig_en && dsel != `APC_DSEL_UNUSED |=> debug_pin_out == $past(dig_test_in[dsel]))
        else $error("debug pin does not show selected channel");

    a_dsel_unused: assert property (@(posedge core_clk) disable iff (!rst_b)
        dsel == `APC_DSEL_UNUSED |=> !debug_pin_out)
        else $error("unimplemented test channel drove the pin");

    a_slave_sync: assert property (@(posedge core_clk) disable iff (!rst_b)
        ext_sync_select == (ms_mode == apc_pkg::APC_MS_SLAVE))
        else $error("sync select disagrees with slave mode");

endmodule

// ---- verification/test_analog_peripheral_control_regs.sv ----
`timescale 1ns/1ps
`include "apc_map.svh"

module test_analog_peripheral_control_regs;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic                       core_clk;
    logic                       rst_b;
    apc_pkg::apc_bus_req_t      bus_req;
    logic [7:0]                 rd_data;
    logic [7:0]                 current_demand;
    logic [7:0]                 voltage_demand;
    logic                       loop_pwm_primary;
    logic                       loop_pwm_secondary;
    logic                       overvoltage_active;
    logic [6:0]                 dig_test_in;
    logic [7:0]                 current_dac_code;
    logic [7:0]                 aux_dac_code;
    logic                       aux_ref_to_pin;
    logic [7:0]                 loop_demand;
    logic                       primary_gate_drive;
    logic                       secondary_gate_drive;
    logic                       sense_pin_pullup_enable;
    apc_pkg::apc_ms_mode_t      ms_mode;
    logic                       ext_sync_select;
    logic                       debug_pin_out;
    logic                       debug_pin_oe;
    logic                       analog_buffer_to_pin;
    logic                       analog_to_adc;
    int                         bad_count;
    int                         n_compared;

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    apc_regs i_dut (
        .core_clk                (core_clk),
        .rst_b                   (rst_b),
        .bus_req                 (bus_req),
        .rd_data                 (rd_data),
        .current_demand          (current_demand),
        .voltage_demand          (voltage_demand),
        .loop_pwm_primary        (loop_pwm_primary),
        .loop_pwm_secondary      (loop_pwm_secondary),
        .overvoltage_active      (overvoltage_active),
        .dig_test_in             (dig_test_in),
        .current_dac_code        (current_dac_code),
        .aux_dac_code            (aux_dac_code),
        .aux_ref_to_pin          (aux_ref_to_pin),
        .loop_demand             (loop_demand),
        .primary_gate_drive      (primary_gate_drive),
        .secondary_gate_drive    (secondary_gate_drive),
        .sense_pin_pullup_enable (sense_pin_pullup_enable),
        .ms_mode                 (ms_mode),
        .ext_sync_select         (ext_sync_select),
        .debug_pin_out           (debug_pin_out),
        .debug_pin_oe            (debug_pin_oe),
        .analog_buffer_to_pin    (analog_buffer_to_pin),
        .analog_to_adc           (analog_to_adc)
    );

    // ----------------------------------------
    // Access and checking tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        chk(rd_data, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Edges from raising a request until the drive rises, capped at 40
    task automatic meas(input bit sec, input int exp);
        int n;
        n = 0;
        @(posedge core_clk);
        if (sec) loop_pwm_secondary <= 1'b1;
        else loop_pwm_primary <= 1'b1;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (n < 40 && (sec ? secondary_gate_drive : primary_gate_drive) !== 1'b1);
        chk(n, exp);
        @(posedge core_clk);
        loop_pwm_secondary <= 1'b0;
        loop_pwm_primary <= 1'b0;
        settle(3);
        chk({primary_gate_drive, secondary_gate_drive}, 16'h0);
    endtask

    // High cycles of each drive over four whole steering periods
    task automatic steer(input logic [7:0] pe, input logic ov, input int ep, input int es);
        int np;
        int ns;
        np = 0;
        ns = 0;
        wr(`APC_OFF_PERIPH_EN, pe);
        overvoltage_active <= ov;
        settle(12);
        repeat (40) begin
            @(posedge core_clk);
            #1;
            np += (primary_gate_drive === 1'b1);
            ns += (secondary_gate_drive === 1'b1);
        end
        chk(np, ep);
        chk(ns, es);
    endtask

    function automatic int dt_edges(input int c);
        return ((c + 1) * `APC_DT_STEP_NS + `APC_CLK_PERIOD_NS - 1) / `APC_CLK_PERIOD_NS + 1;
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] codes [3];
        logic [6:0] hot;
        codes = '{8'h00, 8'hFF, 8'hA5};
        bus_req = '0;
        rst_b = 1'b0;
        current_demand = 8'h00;
        voltage_demand = 8'h00;
        loop_pwm_primary = 1'b0;
        loop_pwm_secondary = 1'b0;
        overvoltage_active = 1'b0;
        dig_test_in = 7'h00;
        bad_count = 0;
        n_compared = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        chk(analog_to_adc, 16'h1);
        chk({primary_gate_drive, secondary_gate_drive, debug_pin_oe}, 16'h0);
        rchk(`APC_OFF_SETPOINT, 8'h00);
        rchk(`APC_OFF_AUX_REF, 8'h00);
        rchk(`APC_OFF_PERIPH_EN, 8'h00);
        foreach (codes[i]) begin
            wr(`APC_OFF_SETPOINT, codes[i]);
            wr(`APC_OFF_AUX_REF, ~codes[i]);
            rchk(`APC_OFF_SETPOINT, codes[i]);
            chk(current_dac_code, codes[i]);
            chk(aux_dac_code, 8'(~codes[i]));
        end
        wr(`APC_OFF_PERIPH_EN, 8'hFF);
        rchk(`APC_OFF_PERIPH_EN, 8'hF7);
        current_demand <= 8'h40;
        voltage_demand <= 8'h30;
        settle(3);
        chk(loop_demand, 8'h30);
        current_demand <= 8'h20;
        voltage_demand <= 8'h90;
        settle(3);
        chk(loop_demand, 8'h20);
        for (int m = 0; m < 4; m++) begin
            wr(`APC_OFF_MODE, {m[1:0], 6'h00});
            settle(2);
            chk(ms_mode, m[1:0]);
            chk(aux_ref_to_pin, m == 1);
            chk(ext_sync_select, m == 2);
        end
        wr(`APC_OFF_PERIPH_EN, 8'h04);
        settle(2);
        chk(sense_pin_pullup_enable, 16'h1);
        wr(`APC_OFF_PERIPH_EN, 8'h00);
        settle(2);
        chk(sense_pin_pullup_enable, 16'h0);
        // Longest primary delay against shortest secondary delay
        wr(`APC_OFF_DEADTIME, 8'hF0);
        wr(`APC_OFF_PERIPH_EN, 8'hC0);
        settle(2);
        meas(1'b0, dt_edges(15));
        meas(1'b1, dt_edges(0));
        wr(`APC_OFF_DEADTIME, 8'h0F);
        meas(1'b0, dt_edges(0));
        meas(1'b1, dt_edges(15));
        wr(`APC_OFF_PERIPH_EN, 8'hF0);
        settle(2);
        meas(1'b0, 1);
        meas(1'b1, 1);
        wr(`APC_OFF_PERIPH_EN, 8'h30);
        settle(2);
        meas(1'b0, 40);
        meas(1'b1, 40);
        wr(`APC_OFF_STEER_TIMING, 8'h03);
        wr(`APC_OFF_STATUS, 8'h09);
        dig_test_in <= 7'h00; // Digital test channels held quiet while steering
        steer(8'hF2, 1'b0, 12, 0);
        steer(8'hF1, 1'b0, 0, 0);
        steer(8'hF1, 1'b1, 0, 12);
        steer(8'hF3, 1'b1, 12, 0);
        for (int s = 0; s < 8; s++) begin
            hot = 7'(8'h01 << s);
            wr(`APC_OFF_BLOCK_EN, {1'b1, s[2:0], 4'h0});
            dig_test_in <= hot;
            settle(2);
            chk(debug_pin_out, s < 7);
            chk(debug_pin_oe, 16'h1);
            dig_test_in <= ~hot;
            settle(2);
            chk(debug_pin_out, 16'h0);
        end
        wr(`APC_OFF_BLOCK_EN, 8'h01);
        settle(2);
        chk({analog_buffer_to_pin, analog_to_adc}, 16'h2);
        dig_test_in <= 7'h01;
        wr(`APC_OFF_BLOCK_EN, 8'h81);
        settle(2);
        chk({debug_pin_out, analog_buffer_to_pin}, 16'h2);
        wr(`APC_OFF_BLOCK_EN, 8'hFF);
        rchk(`APC_OFF_BLOCK_EN, 8'hF1);
        // Second reset in mid-run must clear everything again
        @(posedge core_clk);
        rst_b <= 1'b0;
        @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(`APC_OFF_PERIPH_EN, 8'h00);
        chk(analog_to_adc, 16'h1);
        rchk(`APC_OFF_STATUS, 8'h04);
        conclude();
    end

    // Whole run is a few hundred cycles
    initial begin
        #200000;
        bad_count++;
        conclude();
    end

endmodule
